// ### design/lwc_pkg.sv
// constants, states and carriers of the low power wake controller
package lwc_pkg;
    // clock and slow oscillator timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SLOW_PERIOD_NS = 16000;
    localparam int SLOW_DIV_CYC   = (SLOW_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] WAKE_SLOW_CLKS = 12'h800;
    localparam logic [11:0] WAKE_FAST_CLKS = 12'h020;
    localparam logic [18:0] WDT_8K   = 19'h02000;
    localparam logic [18:0] WDT_16K  = 19'h04000;
    localparam logic [18:0] WDT_64K  = 19'h10000;
    localparam logic [18:0] WDT_256K = 19'h40000;
    // register byte addresses
    localparam logic [7:0] ADDR_CLKMD  = 8'h00;
    localparam logic [7:0] ADDR_MISC   = 8'h04;
    localparam logic [7:0] ADDR_DIE    = 8'h08;
    localparam logic [7:0] ADDR_PORT   = 8'h0C;
    localparam logic [7:0] ADDR_DIR    = 8'h10;
    localparam logic [7:0] ADDR_PULL   = 8'h14;
    localparam logic [7:0] ADDR_T16M   = 8'h18;
    localparam logic [7:0] ADDR_T16CNT = 8'h1C;
    localparam logic [7:0] ADDR_CMPC   = 8'h20;
    localparam logic [7:0] ADDR_CMPS   = 8'h24;
    localparam logic [7:0] ADDR_STAT   = 8'h28;
    // reset values and the input enable write mask
    localparam logic [7:0] CLKMD_RST = 8'hF6;
    localparam logic [7:0] MISC_RST  = 8'h00;
    localparam logic [7:0] DIE_RST   = 8'hF9;
    localparam logic [7:0] PORT_RST  = 8'h00;
    localparam logic [7:0] DIR_RST   = 8'h00;
    localparam logic [7:0] PULL_RST  = 8'h00;
    localparam logic [7:0] T16M_RST  = 8'h00;
    localparam logic [7:0] CMPC_RST  = 8'h00;
    localparam logic [7:0] CMPS_RST  = 8'h00;
    localparam logic [7:0] DIE_MASK  = 8'hF9;
    // field positions
    localparam int CLKMD_PIN_RST = 0;
    localparam int CLKMD_WDT_EN  = 1;
    localparam int CLKMD_SLOW_EN = 2;
    localparam int CLKMD_FAST_EN = 4;
    localparam int MISC_FAST_WAKE = 5;
    localparam int CMPC_EN    = 7;
    localparam int CMPC_RES   = 6;
    localparam int CMPS_WAKE  = 6;
    localparam int OD_PIN     = 5;
    localparam int IRQ_PIN    = 0;
    localparam int TCLK_PIN   = 4;
    // timer clock sources
    localparam logic [2:0] TSRC_SYS  = 3'h1;
    localparam logic [2:0] TSRC_PA4  = 3'h3;
    localparam logic [2:0] TSRC_FAST = 3'h4;
    localparam logic [2:0] TSRC_SLOW = 3'h6;
    localparam logic [2:0] TSRC_PA0  = 3'h7;

    typedef enum logic [1:0] {
        LWC_RUN   = 2'b00,
        LWC_LIGHT = 2'b01,
        LWC_WAKE  = 2'b11,
        LWC_DEEP  = 2'b10
    } lwc_state_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } lwc_pad_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic fast_osc_en;
        logic slow_osc_en;
        logic otp_en;
        logic resume;
        logic cpu_restart;
        logic ram_keep;
    } lwc_pwr_t;
endpackage

// ### design/lwc_wake_ctrl.sv
// power mode, wake and port pad control with avalon register access
//
// Overview of operation
// - light sleep gates only cpu clock and program memory
// - sleeping timer stops on cpu_system_clock or dead osc
// - pin toggle wakes only if enabled
// - non-cpu_system_clock timer reaching value wakes light sleep
// - comparator wake needs enable and wake bits
// - timer bit 8 event after 256 timer counts
// - deep sleep stops both oscillators at once
// - deep sleep retains memory and registers
// - only pin toggles leave deep sleep
// - pin wake continues program, not reset
// - program memory off in both sleeps
// - wake latency 2048 or 32 slow clocks
// - output low forces pull-up off
// - output-mode read returns data register
// - open-drain pin only pulls low or floats
// - pull-up follows pull bit otherwise
// - any reset restores defaults, restarts at zero
// - pin or watchdog reset keeps data memory
// - misc bit 5 selects fast wake
// - clock mode bit 1 enables watchdog
// - input enable bits gate pin wake
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module lwc_wake_ctrl (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // avalon slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // processor core
    input  wire logic        stop_light,
    input  wire logic        stop_deep,
    input  wire logic        wdt_clear,
    // pins and wake sources
    input  wire logic [7:0]  pad_in,
    input  wire logic        external_reset_pin_n,
    input  wire logic        pwm_tmr_evt,
    input  wire logic        pwm_tmr_on_cpu_system_clock,
    input  wire logic        cmp_result,
    // pad and power controls
    output lwc_pkg::lwc_pad_t pad,
    output lwc_pkg::lwc_pwr_t pwr
);
    logic [7:0]  clkmd, misc, die, port_data_reg, dir, pull, t16m, cmpc, cmps;
    logic [7:0]  next_clkmd, next_misc, next_die, next_port, next_dir, next_pull;
    logic [7:0]  next_t16m, next_cmpc, next_cmps;
    logic [15:0] t16_cnt, next_t16_cnt;
    logic [5:0]  t16_pre, next_t16_pre;
    logic [18:0] wdt_cnt, next_wdt_cnt;
    logic [10:0] slow_div, next_slow_div;
    logic [11:0] wake_cnt, next_wake_cnt;
    logic [7:0]  pad_prev;
    logic        cmp_prev;
    logic [1:0]  cause, next_cause;
    lwc_pkg::lwc_state_t state, next_state;
    lwc_pkg::lwc_pwr_t   next_pwr;
    lwc_pkg::lwc_pad_t   next_pad;
    logic [31:0] next_rdata;
    logic        next_wait;
    logic        wr_go, slow_run, slow_tick, soft_rst, wdt_to;
    logic        src_tick, t16_step, t16_evt, t16_wake, pin_tog, cmp_wake, light_wake;
    logic [5:0]  pre_mask;
    logic [18:0] wdt_limit;
    logic [7:0]  port_rd;

    // bus write completes at the edge that sees waitrequest low
    assign wr_go = avs_write & ~avs_waitrequest;

    // slow oscillator tick from a divider
    assign slow_run  = (clkmd[lwc_pkg::CLKMD_SLOW_EN] && state != lwc_pkg::LWC_DEEP)
                       || state == lwc_pkg::LWC_WAKE;
    assign slow_tick = slow_run && slow_div == 11'(lwc_pkg::SLOW_DIV_CYC - 1);

    always_comb begin
        case (misc[1:0])
            2'b00:   wdt_limit = lwc_pkg::WDT_8K;
            2'b01:   wdt_limit = lwc_pkg::WDT_16K;
            2'b10:   wdt_limit = lwc_pkg::WDT_64K;
            default: wdt_limit = lwc_pkg::WDT_256K;
        endcase
    end
    assign wdt_to = clkmd[lwc_pkg::CLKMD_WDT_EN] && slow_tick
                    && wdt_cnt == wdt_limit - 19'h00001;
    assign soft_rst = (clkmd[lwc_pkg::CLKMD_PIN_RST] && !external_reset_pin_n) || wdt_to;

    // timer source stops with cpu clock or osc
    always_comb begin
        case (t16m[7:5])
            lwc_pkg::TSRC_SYS:  src_tick = pwr.cpu_clk_en;
            lwc_pkg::TSRC_FAST: src_tick = pwr.fast_osc_en;
            lwc_pkg::TSRC_SLOW: src_tick = slow_tick;
            lwc_pkg::TSRC_PA4:  src_tick = pad_prev[lwc_pkg::TCLK_PIN]
                                           & ~pad_in[lwc_pkg::TCLK_PIN];
            lwc_pkg::TSRC_PA0:  src_tick = pad_prev[lwc_pkg::IRQ_PIN]
                                           & ~pad_in[lwc_pkg::IRQ_PIN];
            default:            src_tick = 1'b0;
        endcase
        case (t16m[4:3])
            2'b00:   pre_mask = 6'h00;
            2'b01:   pre_mask = 6'h03;
            2'b10:   pre_mask = 6'h0F;
            default: pre_mask = 6'h3F;
        endcase
    end
    assign t16_step = src_tick && (t16_pre & pre_mask) == pre_mask;
    // event when selected bit 8..15 changes
    assign next_t16_cnt = t16_step ? t16_cnt + 16'h0001 : t16_cnt;
    assign t16_evt = t16_step && (t16_cnt[4'(8 + t16m[2:0])]
                                  != next_t16_cnt[4'(8 + t16m[2:0])]);
    // timer wake needs a source other than cpu clock
    assign t16_wake = t16_evt && t16m[7:5] != lwc_pkg::TSRC_SYS;

    assign pin_tog = |((pad_in ^ pad_prev) & ~dir & die & lwc_pkg::DIE_MASK);
    assign cmp_wake = cmpc[lwc_pkg::CMPC_EN] && cmps[lwc_pkg::CMPS_WAKE]
                      && cmp_result != cmp_prev;
    assign light_wake = pin_tog || t16_wake || cmp_wake
                        || (pwm_tmr_evt && !pwm_tmr_on_cpu_system_clock);

    // register, timer and watchdog state
    always_comb begin
        next_clkmd    = clkmd;
        next_misc     = misc;
        next_die      = die;
        next_port     = port_data_reg;
        next_dir      = dir;
        next_pull     = pull;
        next_t16m     = t16m;
        next_cmpc     = cmpc;
        next_cmps     = cmps;
        next_cause    = cause;
        next_t16_pre  = src_tick ? t16_pre + 6'h01 : t16_pre;
        next_wdt_cnt  = (clkmd[lwc_pkg::CLKMD_WDT_EN] && slow_tick) ? wdt_cnt + 19'h00001
                                                                  : wdt_cnt;
        next_slow_div = slow_tick ? 11'h000 : (slow_run ? slow_div + 11'h001 : slow_div);
        if (wdt_clear) begin
            next_wdt_cnt = 19'h00000;
        end
        if (soft_rst) begin
            next_clkmd   = lwc_pkg::CLKMD_RST;
            next_misc    = lwc_pkg::MISC_RST;
            next_die     = lwc_pkg::DIE_RST;
            next_port    = lwc_pkg::PORT_RST;
            next_dir     = lwc_pkg::DIR_RST;
            next_pull    = lwc_pkg::PULL_RST;
            next_t16m    = lwc_pkg::T16M_RST;
            next_cmpc    = lwc_pkg::CMPC_RST;
            next_cmps    = lwc_pkg::CMPS_RST;
            next_t16_pre = 6'h00;
            next_wdt_cnt = 19'h00000;
            next_cause   = {wdt_to, ~wdt_to};
        end else if (wr_go) begin
            case (avs_address)
                lwc_pkg::ADDR_CLKMD: next_clkmd = avs_writedata[7:0];
                lwc_pkg::ADDR_MISC:  next_misc  = avs_writedata[7:0];
                lwc_pkg::ADDR_DIE:   next_die   = avs_writedata[7:0] & lwc_pkg::DIE_MASK;
                lwc_pkg::ADDR_PORT:  next_port  = avs_writedata[7:0];
                lwc_pkg::ADDR_DIR:   next_dir   = avs_writedata[7:0];
                lwc_pkg::ADDR_PULL:  next_pull  = avs_writedata[7:0];
                lwc_pkg::ADDR_T16M:  next_t16m  = avs_writedata[7:0];
                lwc_pkg::ADDR_CMPC:  next_cmpc  = avs_writedata[7:0];
                lwc_pkg::ADDR_CMPS:  next_cmps  = avs_writedata[7:0];
                default:             next_cmps  = cmps;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            clkmd         <= lwc_pkg::CLKMD_RST;
            misc          <= lwc_pkg::MISC_RST;
            die           <= lwc_pkg::DIE_RST;
            port_data_reg <= lwc_pkg::PORT_RST;
            dir           <= lwc_pkg::DIR_RST;
            pull          <= lwc_pkg::PULL_RST;
            t16m          <= lwc_pkg::T16M_RST;
            cmpc          <= lwc_pkg::CMPC_RST;
            cmps          <= lwc_pkg::CMPS_RST;
            t16_pre       <= 6'h00;
            t16_cnt       <= 16'h0000;
            wdt_cnt       <= 19'h00000;
            slow_div      <= 11'h000;
            cause         <= 2'b00;
            // edge detectors start at the pin level
            pad_prev      <= pad_in;
            cmp_prev      <= cmp_result;
        end else begin
            clkmd         <= next_clkmd;
            misc          <= next_misc;
            die           <= next_die;
            port_data_reg <= next_port;
            dir           <= next_dir;
            pull          <= next_pull;
            t16m          <= next_t16m;
            cmpc          <= next_cmpc;
            cmps          <= next_cmps;
            t16_pre       <= next_t16_pre;
            wdt_cnt       <= next_wdt_cnt;
            slow_div      <= next_slow_div;
            cause         <= next_cause;
            pad_prev      <= pad_in;
            cmp_prev      <= cmp_result;
            if (soft_rst) begin
                t16_cnt <= 16'h0000;
            end else if (wr_go && avs_address == lwc_pkg::ADDR_T16CNT) begin
                t16_cnt <= avs_writedata[15:0];
            end else begin
                t16_cnt <= next_t16_cnt;
            end
        end
    end

    // power mode sequencing
    always_comb begin
        next_state    = state;
        next_wake_cnt = wake_cnt;
        next_pwr      = pwr;
        next_pwr.resume      = 1'b0;
        next_pwr.cpu_restart = 1'b0;
        case (state)
            lwc_pkg::LWC_RUN: begin
                if (stop_deep) begin
                    next_state = lwc_pkg::LWC_DEEP;
                end else if (stop_light) begin
                    next_state = lwc_pkg::LWC_LIGHT;
                end
            end
            lwc_pkg::LWC_LIGHT: begin
                if (light_wake) begin
                    next_state    = lwc_pkg::LWC_WAKE;
                    next_wake_cnt = 12'h000;
                end
            end
            lwc_pkg::LWC_DEEP: begin
                // pin toggle is the only way out
                if (pin_tog) begin
                    next_state    = lwc_pkg::LWC_WAKE;
                    next_wake_cnt = 12'h000;
                end
            end
            lwc_pkg::LWC_WAKE: begin
                if (slow_tick) begin
                    next_wake_cnt = wake_cnt + 12'h001;
                    if (next_wake_cnt == (misc[lwc_pkg::MISC_FAST_WAKE]
                            ? lwc_pkg::WAKE_FAST_CLKS : lwc_pkg::WAKE_SLOW_CLKS)) begin
                        next_state      = lwc_pkg::LWC_RUN;
                        next_pwr.resume = 1'b1;
                    end
                end
            end
            default: next_state = lwc_pkg::LWC_RUN;
        endcase
        if (soft_rst) begin
            next_state           = lwc_pkg::LWC_RUN;
            next_pwr.cpu_restart = 1'b1;
            // memory kept on pin or watchdog reset
            next_pwr.ram_keep    = 1'b1;
        end
        next_pwr.cpu_clk_en  = next_state == lwc_pkg::LWC_RUN;
        next_pwr.otp_en      = next_state == lwc_pkg::LWC_RUN;
        // wake does not restart the program
        next_pwr.fast_osc_en = next_clkmd[lwc_pkg::CLKMD_FAST_EN]
                               && next_state != lwc_pkg::LWC_DEEP;
        next_pwr.slow_osc_en = (next_clkmd[lwc_pkg::CLKMD_SLOW_EN]
                                && next_state != lwc_pkg::LWC_DEEP)
                               || next_state == lwc_pkg::LWC_WAKE;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state    <= lwc_pkg::LWC_RUN;
            wake_cnt <= 12'h000;
            pwr      <= '{cpu_clk_en: 1'b1, fast_osc_en: 1'b1, slow_osc_en: 1'b1,
                          otp_en: 1'b1, resume: 1'b0, cpu_restart: 1'b1, ram_keep: 1'b0};
        end else begin
            state    <= next_state;
            wake_cnt <= next_wake_cnt;
            pwr      <= next_pwr;
        end
    end

    // pad drivers, one per pin
    for (genvar i = 0; i < 8; i++) begin : g_pad
        if (i == lwc_pkg::OD_PIN) begin : g_od
            assign next_pad.out[i] = 1'b0;
            assign next_pad.oe[i]  = next_dir[i] & ~next_port[i];
        end else begin : g_pp
            assign next_pad.out[i] = next_port[i];
            assign next_pad.oe[i]  = next_dir[i];
        end
        assign next_pad.pull[i] = next_pull[i] & ~(next_dir[i] & ~next_port[i]);
        assign port_rd[i] = dir[i] ? port_data_reg[i] : pad_in[i];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pad <= '{out: 8'h00, oe: 8'h00, pull: 8'h00};
        end else begin
            pad <= next_pad;
        end
    end

    // avalon slave: one wait cycle, then the answer edge
    always_comb begin
        next_wait  = 1'b1;
        next_rdata = avs_readdata;
        if ((avs_read || avs_write) && avs_waitrequest) begin
            next_wait  = 1'b0;
            next_rdata = 32'h00000000;
            case (avs_address)
                lwc_pkg::ADDR_CLKMD:  next_rdata[7:0]  = clkmd;
                lwc_pkg::ADDR_MISC:   next_rdata[7:0]  = misc;
                lwc_pkg::ADDR_DIE:    next_rdata[7:0]  = die;
                lwc_pkg::ADDR_PORT:   next_rdata[7:0]  = port_rd;
                lwc_pkg::ADDR_DIR:    next_rdata[7:0]  = dir;
                lwc_pkg::ADDR_PULL:   next_rdata[7:0]  = pull;
                lwc_pkg::ADDR_T16M:   next_rdata[7:0]  = t16m;
                lwc_pkg::ADDR_T16CNT: next_rdata[15:0] = t16_cnt;
                lwc_pkg::ADDR_CMPC: begin
                    next_rdata[7:0] = cmpc;
                    next_rdata[lwc_pkg::CMPC_RES] = cmp_result;
                end
                lwc_pkg::ADDR_CMPS:   next_rdata[7:0]  = cmps;
                lwc_pkg::ADDR_STAT:   next_rdata[4:0]  = {pwr.ram_keep, cause, state};
                default:              next_rdata       = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= next_wait;
            avs_readdata    <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ### verif/lwc_core_model.sv
// partner model: core that issues stop pulses, and the pins around the pads
`timescale 1ns/100ps
`default_nettype none
module lwc_core_model (
    // clock and core state
    input  wire logic              mclk,
    input  wire lwc_pkg::lwc_pwr_t pwr,
    // bench commands
    input  wire logic              go_light,
    input  wire logic              go_deep,
    input  wire logic [7:0]        drv,
    // device side
    input  wire lwc_pkg::lwc_pad_t pad,
    output logic [7:0]             pad_in,
    output logic                   stop_light,
    output logic                   stop_deep
);
    // a stopped core cannot issue another stop
    always_ff @(posedge mclk) begin
        stop_light <= go_light & pwr.cpu_clk_en;
        stop_deep  <= go_deep & pwr.cpu_clk_en;
    end
    // wire level: driven pads win, the rest follow the outside driver
    always_comb begin
        pad_in = (pad.oe & pad.out) | (~pad.oe & drv);
    end
endmodule
`default_nettype wire

// ### verif/lwc_wake_ctrl_monitor.sv
// assertion checker on the ports of the low power wake controller
`timescale 1ns/100ps
`default_nettype none
module lwc_wake_ctrl_monitor (
    // clock and reset
    input wire logic              mclk,
    input wire logic              rst,
    // avalon slave
    input wire logic [7:0]        avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    // core and wake sources
    input wire logic              stop_light,
    input wire logic              stop_deep,
    input wire logic              wdt_clear,
    input wire logic [7:0]        pad_in,
    input wire logic              external_reset_pin_n,
    input wire logic              pwm_tmr_evt,
    input wire logic              pwm_tmr_on_cpu_system_clock,
    input wire logic              cmp_result,
    // pad and power
    input wire lwc_pkg::lwc_pad_t pad,
    input wire lwc_pkg::lwc_pwr_t pwr
);
    localparam int MIN_OFF = 31 * lwc_pkg::SLOW_DIV_CYC;
    int off_cnt;
    int next_off_cnt;
    // cycles spent with the cpu clock off
    always_comb begin
        next_off_cnt = pwr.cpu_clk_en ? 0 : off_cnt + 1;
    end
    always_ff @(posedge mclk) begin
        off_cnt <= rst ? 0 : next_off_cnt;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_stop_light;
        pwr.cpu_clk_en && stop_light && !stop_deep;
    endsequence
    sequence s_light_held;
        !pwr.cpu_clk_en && !pwr.otp_en && $stable({pwr.fast_osc_en, pwr.slow_osc_en});
    endsequence
    sequence s_stop_deep;
        pwr.cpu_clk_en && stop_deep;
    endsequence
    sequence s_all_off;
        !pwr.cpu_clk_en && !pwr.fast_osc_en && !pwr.slow_osc_en && !pwr.otp_en;
    endsequence
    AST_LIGHT_ENTRY: assert property (s_stop_light |=> s_light_held)
        else $error("light sleep entry set the wrong enables");
    AST_DEEP_ENTRY: assert property (s_stop_deep |=> s_all_off)
        else $error("deep sleep entry left something running");
    AST_RESTART_RST: assert property ($past(rst) |-> pwr.cpu_restart)
        else $error("no restart after reset");
    AST_RESUME_CONT: assert property (pwr.resume |-> !pwr.cpu_restart ##1 !pwr.resume)
        else $error("resume came with restart or lasted too long");
    AST_WAKE_LATENCY: assert property ($rose(pwr.cpu_clk_en) && !pwr.cpu_restart
                                       |-> off_cnt >= MIN_OFF)
        else $error("cpu clock returned too early");
    AST_OTP_GATED: assert property (pwr.otp_en == pwr.cpu_clk_en)
        else $error("program memory on while sleeping");
    AST_PULL_LOW: assert property ((pad.pull & pad.oe & ~pad.out) == 8'h00)
        else $error("pull-up on a pin driven low");
    AST_OD_NO_HIGH: assert property (pad.oe[lwc_pkg::OD_PIN] |-> !pad.out[lwc_pkg::OD_PIN])
        else $error("open drain pin driven high");
endmodule
bind lwc_wake_ctrl lwc_wake_ctrl_monitor u_mon (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop_light(stop_light), .stop_deep(stop_deep),
    .wdt_clear(wdt_clear), .pad_in(pad_in), .external_reset_pin_n(external_reset_pin_n),
    .pwm_tmr_evt(pwm_tmr_evt), .pwm_tmr_on_cpu_system_clock(pwm_tmr_on_cpu_system_clock),
    .cmp_result(cmp_result), .pad(pad), .pwr(pwr)
);
`default_nettype wire

// ### verif/tb.sv
// self-checking bench of the low power wake controller
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic              mclk, rst, avs_read, avs_write, avs_waitrequest, stop_light, stop_deep;
    logic              go_light, go_deep, pwm_evt, pwm_sys, cmp, ext_n;
    logic [7:0]        avs_address, pad_in, drv, p, d, u;
    logic [31:0]       avs_writedata, avs_readdata, rd;
    lwc_pkg::lwc_pad_t pad;
    lwc_pkg::lwc_pwr_t pwr;
    int                err_count, n_checks, seed, n;
    int                cyc = 0;
    int                mdl[int];
    logic [7:0]        rv [11] = '{lwc_pkg::CLKMD_RST, 8'h00, lwc_pkg::DIE_RST, 8'h00, 8'h00,
                                   8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [4:0]        tc [7] = '{5'h05, 5'h09, 5'h0A, 5'h0C, 5'h14, 5'h18, 5'h11};
    lwc_wake_ctrl uut (
        .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .stop_light(stop_light), .stop_deep(stop_deep),
        .wdt_clear(1'b0), .pad_in(pad_in), .external_reset_pin_n(ext_n),
        .pwm_tmr_evt(pwm_evt), .pwm_tmr_on_cpu_system_clock(pwm_sys), .cmp_result(cmp),
        .pad(pad), .pwr(pwr)
    );
    lwc_core_model u_core (
        .mclk(mclk), .pwr(pwr), .go_light(go_light), .go_deep(go_deep), .drv(drv),
        .pad(pad), .pad_in(pad_in), .stop_light(stop_light), .stop_deep(stop_deep)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            final_report;
        end
    end
    task final_report;
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, a, {24'h0, v});
        if (a == lwc_pkg::ADDR_DIE)
            mdl[a] = v & lwc_pkg::DIE_MASK;
        else
            mdl[a] = (a == lwc_pkg::ADDR_CMPC) ? v & 8'hBF : v;
    endtask
    task rdc(input logic [7:0] a);
        logic [31:0] e;
        if (a == lwc_pkg::ADDR_PORT)
            e = (mdl[lwc_pkg::ADDR_DIR] & mdl[a]) | (~mdl[lwc_pkg::ADDR_DIR] & drv);
        else if (a == lwc_pkg::ADDR_CMPC)
            e = mdl[a] | (cmp << 6);
        else
            e = mdl.exists(a) ? mdl[a] : 0;
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task reset_all;
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        mdl.delete();
        foreach (rv[i]) mdl[i * 4] = rv[i];
    endtask
    task cfg(input logic [7:0] die);
        wr(lwc_pkg::ADDR_MISC, 8'h20);
        wr(lwc_pkg::ADDR_CLKMD, 8'hF4);
        wr(lwc_pkg::ADDR_DIE, die);
        wr(lwc_pkg::ADDR_CMPC, 8'h80);
        wr(lwc_pkg::ADDR_CMPS, 8'h40);
    endtask
    task sleep(input logic deep);
        go_light <= !deep;
        go_deep <= deep;
        @(posedge mclk);
        go_light <= 1'b0;
        go_deep <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(pwr.cpu_clk_en, 0);
        chk(pwr.otp_en, 0);
        chk({pwr.fast_osc_en, pwr.slow_osc_en}, deep ? 0 : 3);
        mdl[lwc_pkg::ADDR_STAT] = deep ? 2 : 1;
        rdc(lwc_pkg::ADDR_STAT);
    endtask
    initial begin
        seed = 32'h039b;
        {rst, avs_read, avs_write, go_light, go_deep, pwm_evt, pwm_sys, cmp, ext_n} = 9'h101;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        drv = 8'h00;
        reset_all;
        for (int i = 0; i < 12; i++) if (i != 7) rdc(i * 4);
        repeat (8) begin
            p = $random(seed);
            d = $random(seed);
            u = $random(seed);
            drv <= $random(seed);
            wr(lwc_pkg::ADDR_PORT, p);
            wr(lwc_pkg::ADDR_DIR, d);
            wr(lwc_pkg::ADDR_PULL, u);
            wr(lwc_pkg::ADDR_DIE, p ^ u);
            chk(pad.oe, d & ~(p & 8'h20));
            chk(pad.pull, u & ~(d & ~p));
            chk(pad.out, p & 8'hDF);
            rdc(lwc_pkg::ADDR_PORT);
            rdc(lwc_pkg::ADDR_DIE);
        end
        reset_all;
        cfg(lwc_pkg::DIE_RST);
        sleep(1'b0);
        drv[3] <= ~drv[3];
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pwr.resume !== 1'b1 && n < 60000);
        chk(n >= 31 * lwc_pkg::SLOW_DIV_CYC && n <= 33 * lwc_pkg::SLOW_DIV_CYC, 1);
        @(posedge mclk);
        chk(pwr.cpu_clk_en, 1);
        chk(pwr.cpu_restart, 0);
        mdl[lwc_pkg::ADDR_STAT] = 0;
        rdc(lwc_pkg::ADDR_STAT);
        rdc(lwc_pkg::ADDR_MISC);
        foreach (tc[i]) begin
            reset_all;
            pwm_sys <= tc[i][1];
            cfg(tc[i][3:2] == 2'd3 ? 8'h00 : lwc_pkg::DIE_RST);
            if (tc[i][4] && tc[i][3:2] != 2'd1) wr(lwc_pkg::ADDR_CMPC, 8'h00);
            sleep(tc[i][4]);
            case (tc[i][3:2])
                2'd1: cmp <= ~cmp;
                2'd2: pwm_evt <= 1'b1;
                default: drv[3] <= ~drv[3];
            endcase
            @(posedge mclk);
            pwm_evt <= 1'b0;
            repeat (4) @(posedge mclk);
            if (tc[i][0]) mdl[lwc_pkg::ADDR_STAT] = 3;
            rdc(lwc_pkg::ADDR_STAT);
        end
        // fast osc timer wakes after 256 counts
        reset_all;
        cfg(lwc_pkg::DIE_RST);
        wr(lwc_pkg::ADDR_T16M, 8'h80);
        wr(lwc_pkg::ADDR_T16CNT, 8'h00);
        sleep(1'b0);
        repeat (245) @(posedge mclk);
        rdc(lwc_pkg::ADDR_STAT);
        mdl[lwc_pkg::ADDR_STAT] = 3;
        rdc(lwc_pkg::ADDR_STAT);
        wr(lwc_pkg::ADDR_CLKMD, 8'hF5);
        ext_n <= 1'b0;
        @(posedge mclk);
        ext_n <= 1'b1;
        @(posedge mclk);
        chk({pwr.cpu_restart, pwr.ram_keep}, 3);
        foreach (rv[i]) mdl[i * 4] = rv[i];
        mdl[lwc_pkg::ADDR_STAT] = 8'h14;
        rdc(lwc_pkg::ADDR_STAT);
        rdc(lwc_pkg::ADDR_CLKMD);
        final_report;
    end
endmodule
`default_nettype wire
